// File: shared/pesp_pkg.sv
// package: character codes, limits and the state enumeration for the escape parser
package pesp_pkg;
    localparam logic [7:0] CH_ESC = 8'h1b;
    localparam logic [7:0] CH_AMP = 8'h26;
    localparam logic [7:0] CH_A_LOW = 8'h61;
    localparam logic [7:0] CH_K_LOW = 8'h6b;
    localparam logic [7:0] CH_PLUS = 8'h2b;
    localparam logic [7:0] CH_MINUS = 8'h2d;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_1 = 8'h31;
    localparam logic [7:0] CH_2 = 8'h32;
    localparam logic [7:0] CH_3 = 8'h33;
    localparam logic [7:0] CH_4 = 8'h34;
    localparam logic [7:0] CH_5 = 8'h35;
    localparam logic [7:0] CH_QUEST = 8'h3f;
    localparam logic [7:0] CH_AT = 8'h40;
    localparam logic [7:0] CH_G_UP = 8'h47;
    localparam logic [7:0] CH_UP_A = 8'h41;
    localparam logic [7:0] CH_UP_Z = 8'h5a;
    localparam logic [7:0] CH_C_UP = 8'h43;
    localparam logic [7:0] CH_E_UP = 8'h45;
    localparam logic [7:0] CH_L_UP = 8'h4c;
    localparam logic [7:0] CH_M_UP = 8'h4d;
    localparam logic [7:0] CH_R_UP = 8'h52;
    localparam logic [7:0] CH_T_UP = 8'h54;
    localparam logic [7:0] CH_U_UP = 8'h55;
    localparam logic [7:0] CH_Y_UP = 8'h59;
    localparam logic [7:0] CH_Z_UP = 8'h5a;
    localparam logic [7:0] CH_CARET = 8'h5e;
    localparam logic [7:0] CH_F_LOW = 8'h66;
    localparam logic [7:0] CH_G_LOW = 8'h67;
    localparam logic [7:0] CH_DC1 = 8'h11;
    // companion clear-tab terminator is unprinted; chosen here
    localparam logic [7:0] CH_TCLR = 8'h55;
    localparam logic [7:0] MAX_COL = 8'h84;
    localparam logic [7:0] MIN_COL = 8'h01;
    localparam logic [7:0] MAX_FEED = 8'h3f;
    localparam logic [7:0] LEFT_RST = 8'h01;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ESC = 3'b001,
        ST_AMP = 3'b010,
        ST_CUR = 3'b011,
        ST_LAT = 3'b100,
        ST_ERR = 3'b101
    } pesp_state_t;
endpackage

// File: hw/pesp_parser.sv
// escape sequence parser for a thermal line printer
`timescale 1ns/100ps

module pesp_parser #(
    parameter int NUM_COLS = 133
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // host character stream
    input wire logic in_valid,
    input wire logic [7:0] in_char,
    input wire logic serial_active,
    // print path
    output logic out_valid,
    output logic [7:0] out_char,
    input wire logic line_end,
    // head position reported by mechanism
    input wire logic [7:0] head_col,
    // head and paper commands
    output logic move_valid,
    output logic [7:0] move_col,
    output logic feed_valid,
    output logic [7:0] feed_lines,
    output logic page_adv,
    // settings
    output logic [7:0] left_margin,
    output logic [7:0] right_margin,
    output logic [NUM_COLS-1:0] tab_stops,
    output logic display_fn,
    output logic [2:0] enhance,
    output logic enh_latch,
    // status and link actions
    output logic status_req,
    output logic primary_status_req,
    output logic modem_drop,
    output logic soft_reset,
    output logic error_seen
);

    // column 132 must exist and 8-bit column values must reach every stop
    if (NUM_COLS < 133 || NUM_COLS > 256) begin : gen_cols_check
        $error("NUM_COLS must be 133..256");
    end

    ////////////////////////////////////////////////////////////////////
    pesp_pkg::pesp_state_t state, next_state;
    logic [7:0] num, next_num;
    logic neg, next_neg, signed_seen, next_signed_seen;
    logic stat_wait, next_stat_wait;
    logic [7:0] next_left, next_right, next_move_col, next_feed;
    logic [NUM_COLS-1:0] next_tabs;
    logic next_display, next_latch, next_error;
    logic [2:0] next_enh;
    logic [7:0] next_out_char;
    logic next_out_valid, next_move_valid, next_feed_valid, next_page;
    logic next_status, next_prim, next_modem, next_soft;
    logic [7:0] clamp_col;
    logic is_upper, is_digit;

    assign is_upper = in_char >= pesp_pkg::CH_UP_A
        && in_char <= pesp_pkg::CH_UP_Z;
    assign is_digit = in_char >= pesp_pkg::CH_0 && in_char <= pesp_pkg::CH_9;
    // values above the widest column saturate; zero is lifted to one
    assign clamp_col = (num > pesp_pkg::MAX_COL) ? pesp_pkg::MAX_COL :
        (num < pesp_pkg::MIN_COL) ? pesp_pkg::MIN_COL : num;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        next_num = num;
        next_neg = neg;
        next_signed_seen = signed_seen;
        next_stat_wait = stat_wait;
        next_left = left_margin;
        next_right = right_margin;
        next_tabs = tab_stops;
        next_display = display_fn;
        next_latch = enh_latch;
        next_enh = enhance;
        next_error = error_seen;
        next_out_char = out_char;
        next_out_valid = 1'b0;
        next_move_valid = 1'b0;
        next_move_col = move_col;
        next_feed_valid = 1'b0;
        next_feed = feed_lines;
        next_page = 1'b0;
        next_status = 1'b0;
        next_prim = 1'b0;
        next_modem = 1'b0;
        next_soft = 1'b0;
        if (line_end && !enh_latch) begin
            next_enh = 3'h0;
        end
        // serial status waits for the host's DC1 trigger
        if (in_valid && stat_wait && in_char == pesp_pkg::CH_DC1) begin
            next_stat_wait = 1'b0;
            next_status = 1'b1;
        end else if (in_valid && in_char == pesp_pkg::CH_ESC) begin
            next_state = pesp_pkg::ST_ESC;
            next_num = 8'h00;
            next_neg = 1'b0;
            next_signed_seen = 1'b0;
        end else if (in_valid) begin
            unique case (state)
                pesp_pkg::ST_IDLE: begin
                    next_out_valid = 1'b1;
                    next_out_char = in_char;
                end
                pesp_pkg::ST_ESC: begin
                    next_state = pesp_pkg::ST_IDLE;
                    unique case (in_char)
                        pesp_pkg::CH_1:
                            next_tabs[head_col] = 1'b1;
                        pesp_pkg::CH_2:
                            next_tabs[head_col] = 1'b0;
                        pesp_pkg::CH_3:
                            next_tabs = '0;
                        pesp_pkg::CH_4:
                            next_left = head_col;
                        pesp_pkg::CH_5:
                            next_right = head_col;
                        pesp_pkg::CH_9: begin
                            next_left = pesp_pkg::LEFT_RST;
                            next_right = pesp_pkg::MAX_COL;
                        end
                        pesp_pkg::CH_QUEST: begin
                            if (serial_active)
                                next_stat_wait = 1'b1;
                            else
                                next_status = 1'b1;
                        end
                        pesp_pkg::CH_E_UP: begin
                            // power-on state: same values as srst
                            next_left = pesp_pkg::LEFT_RST;
                            next_right = pesp_pkg::MAX_COL;
                            next_tabs = '0;
                            next_display = 1'b0;
                            next_latch = 1'b0;
                            next_enh = 3'h0;
                            next_error = 1'b0;
                            next_stat_wait = 1'b0;
                            next_soft = 1'b1;
                        end
                        pesp_pkg::CH_U_UP:
                            next_page = 1'b1;
                        pesp_pkg::CH_Y_UP:
                            next_display = 1'b1;
                        pesp_pkg::CH_Z_UP:
                            next_display = 1'b0;
                        pesp_pkg::CH_CARET:
                            next_prim = 1'b1;
                        pesp_pkg::CH_F_LOW:
                            next_modem = serial_active;
                        pesp_pkg::CH_G_LOW: begin
                            next_soft = 1'b1;
                            next_error = 1'b0;
                            next_stat_wait = 1'b0;
                        end
                        pesp_pkg::CH_AMP:
                            next_state = pesp_pkg::ST_AMP;
                        default: begin
                            next_error = 1'b1;
                            if (!is_upper)
                                next_state = pesp_pkg::ST_ERR;
                        end
                    endcase
                end
                pesp_pkg::ST_AMP: begin
                    if (in_char == pesp_pkg::CH_A_LOW) begin
                        next_state = pesp_pkg::ST_CUR;
                    end else if (in_char == pesp_pkg::CH_K_LOW) begin
                        next_state = pesp_pkg::ST_LAT;
                    end else begin
                        next_error = 1'b1;
                        next_state = is_upper ? pesp_pkg::ST_IDLE
                            : pesp_pkg::ST_ERR;
                    end
                end
                pesp_pkg::ST_CUR, pesp_pkg::ST_LAT: begin
                    if (is_digit) begin
                        // saturate so overlong numbers still clamp
                        if (num > 8'h19 || (num == 8'h19
                                && in_char > pesp_pkg::CH_5))
                            next_num = 8'hff;
                        else
                            next_num = 8'((num << 3) + (num << 1)
                                + (in_char - pesp_pkg::CH_0));
                    end else if (state == pesp_pkg::ST_CUR
                            && !signed_seen && num == 8'h00
                            && (in_char == pesp_pkg::CH_PLUS
                            || in_char == pesp_pkg::CH_MINUS)) begin
                        next_signed_seen = 1'b1;
                        next_neg = in_char == pesp_pkg::CH_MINUS;
                    end else if (in_char >= pesp_pkg::CH_AT
                            && in_char <= pesp_pkg::CH_G_UP
                            && !(state == pesp_pkg::ST_CUR
                            && in_char == pesp_pkg::CH_C_UP)
                            && !(state == pesp_pkg::ST_LAT
                            && in_char == pesp_pkg::CH_E_UP)) begin
                        next_state = pesp_pkg::ST_IDLE;
                        next_enh = in_char[2:0];
                    end else begin
                        next_state = pesp_pkg::ST_IDLE;
                        if (state == pesp_pkg::ST_LAT
                                && in_char == pesp_pkg::CH_E_UP
                                && num <= 8'h01) begin
                            next_latch = num[0];
                        end else if (state == pesp_pkg::ST_CUR) begin
                            unique case (in_char)
                                pesp_pkg::CH_C_UP: begin
                                    next_move_valid = 1'b1;
                                    if (!signed_seen)
                                        next_move_col = num;
                                    else if (neg)
                                        next_move_col = (num > head_col)
                                            ? 8'h00 : 8'(head_col - num);
                                    else
                                        next_move_col = (num > 8'(pesp_pkg
                                            ::MAX_COL - head_col))
                                            ? pesp_pkg::MAX_COL
                                            : 8'(head_col + num);
                                end
                                pesp_pkg::CH_L_UP:
                                    next_left = clamp_col;
                                pesp_pkg::CH_M_UP:
                                    next_right = clamp_col;
                                pesp_pkg::CH_R_UP: begin
                                    next_feed_valid = 1'b1;
                                    next_feed = (num > pesp_pkg::MAX_FEED)
                                        ? pesp_pkg::MAX_FEED : num;
                                end
                                pesp_pkg::CH_T_UP:
                                    next_tabs[clamp_col] = 1'b1;
                                pesp_pkg::CH_TCLR:
                                    next_tabs[clamp_col] = 1'b0;
                                default: begin
                                    next_error = 1'b1;
                                    if (!is_upper)
                                        next_state = pesp_pkg::ST_ERR;
                                end
                            endcase
                        end else begin
                            next_error = 1'b1;
                            if (!is_upper)
                                next_state = pesp_pkg::ST_ERR;
                        end
                    end
                end
                pesp_pkg::ST_ERR: begin
                    if (is_upper)
                        next_state = pesp_pkg::ST_IDLE;
                end
                default: next_state = pesp_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= pesp_pkg::ST_IDLE;
            num <= 8'h00;
            neg <= 1'b0;
            signed_seen <= 1'b0;
            stat_wait <= 1'b0;
            left_margin <= pesp_pkg::LEFT_RST;
            right_margin <= pesp_pkg::MAX_COL;
            tab_stops <= '0;
            display_fn <= 1'b0;
            enh_latch <= 1'b0;
            enhance <= 3'h0;
            error_seen <= 1'b0;
            out_char <= 8'h00;
            out_valid <= 1'b0;
            move_valid <= 1'b0;
            move_col <= 8'h00;
            feed_valid <= 1'b0;
            feed_lines <= 8'h00;
            page_adv <= 1'b0;
            status_req <= 1'b0;
            primary_status_req <= 1'b0;
            modem_drop <= 1'b0;
            soft_reset <= 1'b0;
        end else begin
            state <= next_state;
            num <= next_num;
            neg <= next_neg;
            signed_seen <= next_signed_seen;
            stat_wait <= next_stat_wait;
            left_margin <= next_left;
            right_margin <= next_right;
            tab_stops <= next_tabs;
            display_fn <= next_display;
            enh_latch <= next_latch;
            enhance <= next_enh;
            error_seen <= next_error;
            out_char <= next_out_char;
            out_valid <= next_out_valid;
            move_valid <= next_move_valid;
            move_col <= next_move_col;
            feed_valid <= next_feed_valid;
            feed_lines <= next_feed;
            page_adv <= next_page;
            status_req <= next_status;
            primary_status_req <= next_prim;
            modem_drop <= next_modem;
            soft_reset <= next_soft;
        end
    end

endmodule

// File: verification/pesp_parser_monitor.sv
// assertion checker watching the escape parser ports
`timescale 1ns/100ps
module pesp_parser_monitor #(
    parameter int NUM_COLS = 133
) (
    // clock, reset and host stream
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    input wire logic [7:0] in_char,
    input wire logic serial_active,
    input wire logic line_end,
    // parser outputs
    input wire logic out_valid,
    input wire logic feed_valid,
    input wire logic [7:0] feed_lines,
    input wire logic page_adv,
    input wire logic [7:0] left_margin,
    input wire logic [7:0] right_margin,
    input wire logic [NUM_COLS-1:0] tab_stops,
    input wire logic display_fn,
    input wire logic [2:0] enhance,
    input wire logic enh_latch,
    input wire logic primary_status_req,
    input wire logic modem_drop,
    input wire logic soft_reset,
    input wire logic error_seen
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // escape and its command byte on consecutive strobes
    sequence esc_then(logic [7:0] c);
        in_valid && in_char == pesp_pkg::CH_ESC ##1 in_valid && in_char == c;
    endsequence
    margin_restore_a: assert property (
        esc_then(pesp_pkg::CH_9) |=> left_margin == 8'h01 && right_margin == 8'h84)
        else $error("margins not widest after restore");
    tab_clear_a: assert property (
        esc_then(pesp_pkg::CH_3) |=> tab_stops == '0)
        else $error("tab stops left after clear all");
    disp_on_a: assert property (
        esc_then(pesp_pkg::CH_Y_UP) |=> display_fn)
        else $error("display flag not set");
    page_adv_a: assert property (
        esc_then(pesp_pkg::CH_U_UP) |=> page_adv ##1 !page_adv)
        else $error("page advance not a single pulse");
    prim_status_a: assert property (
        esc_then(pesp_pkg::CH_CARET) |=> primary_status_req)
        else $error("primary status not requested");
    modem_drop_a: assert property (
        esc_then(pesp_pkg::CH_F_LOW) |=> modem_drop == $past(serial_active))
        else $error("modem drop does not follow serial link");
    soft_reset_a: assert property (
        esc_then(pesp_pkg::CH_G_LOW) |=> soft_reset && !error_seen)
        else $error("soft reset missing or error kept");
    power_on_a: assert property (
        esc_then(pesp_pkg::CH_E_UP) |=> !display_fn && tab_stops == '0 &&
            left_margin == 8'h01)
        else $error("state not back at power-on values");
    feed_limit_a: assert property (
        feed_valid |-> feed_lines <= 8'h3f)
        else $error("feed count above limit");
    plain_origin_a: assert property (
        out_valid |-> $past(in_valid))
        else $error("print char without a host char");
    enh_clear_a: assert property (
        line_end && !enh_latch && !in_valid |=> enhance == 3'h0)
        else $error("enhancements kept at line end while unlatched");
    cover property (esc_then(pesp_pkg::CH_9));
    cover property ($rose(error_seen));
    cover property (feed_valid && feed_lines == 8'h3f);
endmodule

// File: verification/pesp_host_model.sv
// host model feeding characters to the escape parser
`timescale 1ns/100ps
module pesp_host_model (
    // clock
    input wire logic clk,
    // character stream
    output logic in_valid,
    output logic [7:0] in_char
);
    initial begin
        in_valid = 1'b0;
        in_char = 8'h00;
    end
    // back-to-back bytes; idle data is inverted so a stale byte never helps
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(negedge clk);
            in_valid = 1'b1;
            in_char = s[i];
        end
        @(negedge clk);
        in_valid = 1'b0;
        in_char = ~in_char;
    endtask
    // serial status leaves only after this trigger byte
    task automatic trigger();
        send("\021");
    endtask
endmodule

// File: verification/testbench.sv
// self-checking bench for the escape sequence parser
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic serial_active = 1'b0;
    logic line_end = 1'b0;
    logic [7:0] head_col = 8'h0a;
    logic in_valid, out_valid, move_valid, feed_valid, page_adv;
    logic [7:0] in_char, out_char, move_col, feed_lines;
    logic [7:0] left_margin, right_margin;
    logic [132:0] tab_stops;
    logic display_fn, enh_latch, status_req, primary_status_req;
    logic modem_drop, soft_reset, error_seen;
    logic [2:0] enhance;
    int err_total = 0;
    int check_count = 0;
    always #25 clk = ~clk;
    pesp_host_model pesp_host_model_inst (.clk(clk), .in_valid(in_valid),
        .in_char(in_char));
    pesp_parser #(.NUM_COLS(133)) pesp_parser_inst (.clk(clk), .srst(srst),
        .in_valid(in_valid), .in_char(in_char),
        .serial_active(serial_active), .out_valid(out_valid),
        .out_char(out_char), .line_end(line_end), .head_col(head_col),
        .move_valid(move_valid), .move_col(move_col),
        .feed_valid(feed_valid), .feed_lines(feed_lines),
        .page_adv(page_adv), .left_margin(left_margin),
        .right_margin(right_margin), .tab_stops(tab_stops),
        .display_fn(display_fn), .enhance(enhance), .enh_latch(enh_latch),
        .status_req(status_req), .primary_status_req(primary_status_req),
        .modem_drop(modem_drop), .soft_reset(soft_reset),
        .error_seen(error_seen));
    task automatic check(input logic [132:0] seen, input logic [132:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tx(input string s);
        pesp_host_model_inst.send(s);
    endtask
    task automatic complete_run();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_tabs();
        check({left_margin, right_margin}, 16'h0184);
        tx("\0331");
        check(tab_stops[10], 1'b1);
        tx("\0332");
        check(tab_stops[10], 1'b0);
        tx("\0331\0333");
        check(tab_stops, '0);
        tx("\0334");
        check(left_margin, 8'h0a);
        head_col = 8'h28;
        tx("\0335");
        check(right_margin, 8'h28);
        tx("\0339");
        check({left_margin, right_margin}, 16'h0184);
    endtask
    task automatic t_flags();
        tx("\033Y");
        check(display_fn, 1'b1);
        tx("\033Z");
        check(display_fn, 1'b0);
        tx("\033U");
        check(page_adv, 1'b1);
        tx("\033^");
        check(primary_status_req, 1'b1);
        for (int s = 0; s < 2; s++) begin
            serial_active = s[0];
            tx("\033f");
            check(modem_drop, s[0]);
            tx("\033?");
            check(status_req, !s[0]);
        end
        pesp_host_model_inst.trigger();
        check(status_req, 1'b1);
        serial_active = 1'b0;
    endtask
    task automatic t_cursor();
        head_col = 8'h0a;
        tx("\033&a5C");
        check({move_valid, move_col}, 9'h105);
        tx("\033&a+3C");
        check(move_col, 8'h0d);
        tx("\033&a-20C");
        check(move_col, 8'h00);
        tx("\033&a200L");
        check(left_margin, 8'h84);
        tx("\033&a40M");
        check(right_margin, 8'h28);
        tx("\033&a300M");
        check(right_margin, 8'h84);
        tx("\033&a+70R");
        check({feed_valid, feed_lines}, 9'h13f);
        tx("\033&a+259R");
        check({feed_valid, feed_lines}, 9'h13f);
        tx("\033&a132T");
        check(tab_stops[132], 1'b1);
        tx("\033&a140U");
        check(tab_stops[132], 1'b0);
    endtask
    task automatic t_enh();
        string term = "@ABCDEFG";
        for (int i = 0; i < 8; i++) begin
            if (i == 3)
                tx("\033&k0C");
            else
                tx({"\033&a0", term.substr(i, i)});
            check(enhance, i[2:0]);
        end
        // latched first, so the unlatched pass still starts from all three
        for (int l = 1; l >= 0; l--) begin
            tx(l == 1 ? "\033&k1E" : "\033&k0E");
            line_end = 1'b1;
            @(negedge clk);
            line_end = 1'b0;
            check({enh_latch, enhance}, l == 1 ? 4'hf : 4'h0);
        end
    endtask
    task automatic t_error();
        tx("\033x");
        check(error_seen, 1'b1);
        tx("aQ");
        check(out_valid, 1'b0);
        tx("h");
        check({out_valid, out_char}, 9'h168);
        tx("\033x\033Y\0331");
        check(display_fn, 1'b1);
        tx("\033E");
        check({display_fn, error_seen, left_margin, right_margin},
            18'h00184);
        check(tab_stops, '0);
        tx("\033x\033g");
        check({soft_reset, error_seen}, 2'b10);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        t_tabs();
        t_flags();
        t_cursor();
        t_enh();
        t_error();
        complete_run();
    end
    // whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #(3000 * 50);
        err_total++;
        complete_run();
    end
endmodule
bind pesp_parser pesp_parser_monitor #(.NUM_COLS(NUM_COLS))
    pesp_parser_monitor_inst (.clk(clk), .srst(srst), .in_valid(in_valid),
    .in_char(in_char), .serial_active(serial_active), .line_end(line_end),
    .out_valid(out_valid), .feed_valid(feed_valid),
    .feed_lines(feed_lines), .page_adv(page_adv),
    .left_margin(left_margin), .right_margin(right_margin),
    .tab_stops(tab_stops), .display_fn(display_fn), .enhance(enhance),
    .enh_latch(enh_latch), .primary_status_req(primary_status_req),
    .modem_drop(modem_drop), .soft_reset(soft_reset),
    .error_seen(error_seen));
